// ### rtl/lpw_consts.svh
// Constants for the low power wake controller.
`ifndef LPW_CONSTS_SVH
`define LPW_CONSTS_SVH
`define LPW_VEC_RESET 16'hFFFE
`define LPW_VEC_EXT_IRQ 16'hFFFA
`define LPW_VEC_BREAK 16'hFFFC
`define LPW_VEC_CLKGEN 16'hFFF8
`define LPW_VEC_KEYBOARD 16'hFFE0
`define LPW_VEC_T1_OVF 16'hFFF2
`define LPW_VEC_T1_CH1 16'hFFF4
`define LPW_VEC_T1_CH0 16'hFFF6
`define LPW_VEC_T2_OVF 16'hFFEC
`define LPW_VEC_T2_CH1 16'hFFEE
`define LPW_VEC_T2_CH0 16'hFFF0
`define LPW_VEC_SPI_TX 16'hFFE8
`define LPW_VEC_SPI_RX 16'hFFEA
`define LPW_VEC_SER_TX 16'hFFE2
`define LPW_VEC_SER_RX 16'hFFE4
`define LPW_VEC_SER_ERR 16'hFFE6
`define LPW_VEC_ADC 16'hFFDE
`define LPW_VEC_TIMEBASE 16'hFFDC
`define LPW_RECOVERY_LONG 4096
`define LPW_RECOVERY_SHORT 32
`define LPW_SRC_COUNT 16
`endif

// ### rtl/lpw_pkg.sv
// Types shared by the low power wake controller.
`default_nettype none
package lpw_pkg;
  typedef enum logic [2:0] {
    LPW_RUN = 3'b001,
    LPW_WAIT = 3'b010,
    LPW_STOP = 3'b100
  } lpw_mode_t;

  typedef struct packed {
    logic ext_irq;
    logic break_irq;
    logic clkgen_irq;
    logic keyboard_irq;
    logic t1_ovf;
    logic t1_ch1;
    logic t1_ch0;
    logic t2_ovf;
    logic t2_ch1;
    logic t2_ch0;
    logic spi_tx;
    logic spi_rx;
    logic ser_tx;
    logic ser_rx;
    logic ser_err;
    logic adc;
    logic timebase;
  } lpw_irq_t;

  typedef struct packed {
    logic stop_enable;
    logic short_recovery_select;
    logic osc_run_in_stop;
    logic ext_irq_mask;
    logic keyboard_irq_mask;
    logic monitor_enable;
    logic monitor_reset_enable;
    logic monitor_stop_enable;
  } lpw_cfg_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic watchdog_clock_input;
    logic watchdog_prescaler_clear;
    logic ser_run;
    logic spi_run;
    logic spi_reset;
    logic timer_run;
    logic timebase_run;
    logic monitor_run;
  } lpw_gate_t;
endpackage : lpw_pkg
`default_nettype wire

// ### rtl/lpw_sync.sv
// Two flip-flop synchroniser with a falling edge pulse.
`timescale 1ns/1ps
`default_nettype none
module lpw_sync (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Pin side
  input wire logic pin_i,
  // Synchronised side
  output logic level_o,
  output logic fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } lpw_sync_state_t;

  lpw_sync_state_t st;
  lpw_sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  // Idle high so that a low pin at release still counts as an edge later.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= 3'b111;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.s2;
  assign fall_o = st.s3 & ~st.s2;
endmodule : lpw_sync
`default_nettype wire

// ### rtl/lpw_vector_sel.sv
// Priority encoder from pending requests to a vector address.
`timescale 1ns/1ps
`default_nettype none
`include "lpw_consts.svh"
module lpw_vector_sel (
  // Requests
  input wire lpw_pkg::lpw_irq_t irq_i,
  // Result
  output logic any_o,
  output logic [15:0] vector_o
);
  always_comb begin
    any_o = 1'b1;
    vector_o = `LPW_VEC_RESET;
    if (irq_i.break_irq) begin
      vector_o = `LPW_VEC_BREAK;
    end else if (irq_i.ext_irq) begin
      vector_o = `LPW_VEC_EXT_IRQ;
    end else if (irq_i.clkgen_irq) begin
      vector_o = `LPW_VEC_CLKGEN;
    end else if (irq_i.t1_ch0) begin
      vector_o = `LPW_VEC_T1_CH0;
    end else if (irq_i.t1_ch1) begin
      vector_o = `LPW_VEC_T1_CH1;
    end else if (irq_i.t1_ovf) begin
      vector_o = `LPW_VEC_T1_OVF;
    end else if (irq_i.t2_ch0) begin
      vector_o = `LPW_VEC_T2_CH0;
    end else if (irq_i.t2_ch1) begin
      vector_o = `LPW_VEC_T2_CH1;
    end else if (irq_i.t2_ovf) begin
      vector_o = `LPW_VEC_T2_OVF;
    end else if (irq_i.spi_rx) begin
      vector_o = `LPW_VEC_SPI_RX;
    end else if (irq_i.spi_tx) begin
      vector_o = `LPW_VEC_SPI_TX;
    end else if (irq_i.ser_err) begin
      vector_o = `LPW_VEC_SER_ERR;
    end else if (irq_i.ser_rx) begin
      vector_o = `LPW_VEC_SER_RX;
    end else if (irq_i.ser_tx) begin
      vector_o = `LPW_VEC_SER_TX;
    end else if (irq_i.keyboard_irq) begin
      vector_o = `LPW_VEC_KEYBOARD;
    end else if (irq_i.adc) begin
      vector_o = `LPW_VEC_ADC;
    end else if (irq_i.timebase) begin
      vector_o = `LPW_VEC_TIMEBASE;
    end else begin
      any_o = 1'b0;
    end
  end
endmodule : lpw_vector_sel
`default_nettype wire

// ### rtl/lpw_wake_ctrl.sv
// Wait and stop mode controller with wake sources and stop recovery.
// How it works
// - Stop ends only on reset, pin edges, monitor reset, break or timebase.
// - Stop gates the watchdog clock and clears its prescaler.
// - Stop instruction is ignored while the stop enable bit is clear.
// - External pin interrupt stays live in both modes; unmasked it wakes.
// - Keyboard interrupt stays live in both modes; unmasked it wakes.
// - Enabled supply monitor stays live and its reset ends either mode.
// - Serial interface runs in wait and wakes; halts intact in stop.
// - SPI halts in stop, resumes on interrupt exit, resets on reset exit.
// - Timers run in wait and wake; halt intact in stop.
// - Timebase runs in stop only with oscillator on; rollover wakes.
// - Pin reset, watchdog timeout or monitor trip use vector FFFE.
// - External pin falling edge uses vector FFFA.
// - Break wakes from wait or stop, vector FFFC.
// - Clock generator interrupt wakes from wait only, vector FFF8.
// - Keyboard interrupt uses vector FFE0.
// - First timer vectors FFF2, FFF4, FFF6.
// - Second timer vectors FFEC, FFEE, FFF0.
// - SPI vectors FFE8 and FFEA.
// - Serial interface vectors FFE2, FFE4 and FFE6.
// - Converter vector FFDE, timebase vector FFDC.
// - Reset or pin exit from stop holds clocks for 4096 reference cycles.
// - Short recovery bit shortens the hold to 32 cycles.
// - Without oscillator in stop, clocks stop and are held low.
`timescale 1ns/1ps
`default_nettype none
`include "lpw_consts.svh"
module lpw_wake_ctrl #(
  parameter int unsigned RECOVERY_LONG = `LPW_RECOVERY_LONG,
  parameter int unsigned RECOVERY_SHORT = `LPW_RECOVERY_SHORT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Configuration bits
  input wire lpw_pkg::lpw_cfg_t cfg_i,
  // CPU requests, one-cycle pulses
  input wire logic wait_instr_i,
  input wire logic stop_instr_i,
  input wire logic vector_taken_i,
  // Pins from outside the clock domain
  input wire logic ext_reset_n_pin_i,
  input wire logic ext_irq_n_pin_i,
  input wire logic keyboard_n_pin_i,
  // Internal events
  input wire logic watchdog_timeout_i,
  input wire logic monitor_trip_i,
  input wire logic timebase_rollover_i,
  input wire lpw_pkg::lpw_irq_t periph_irq_i,
  // Mode and clock gates
  output lpw_pkg::lpw_mode_t mode_o,
  output lpw_pkg::lpw_gate_t gate_o,
  output logic recovering_o,
  // Vector fetch
  output logic chip_reset_o,
  output logic vector_valid_o,
  output logic [15:0] vector_o
);
  localparam int unsigned CW = 12;

  // The counter is only CW bits wide and needs at least one decrement.
  if (RECOVERY_LONG < 2 || RECOVERY_LONG > (1 << CW)) begin : g_long_bad
    $error("RECOVERY_LONG out of range");
  end
  if (RECOVERY_SHORT < 2 || RECOVERY_SHORT > RECOVERY_LONG) begin : g_short_bad
    $error("RECOVERY_SHORT out of range");
  end

  localparam logic [CW-1:0] LONG_LOAD = CW'(RECOVERY_LONG - 1);
  localparam logic [CW-1:0] SHORT_LOAD = CW'(RECOVERY_SHORT - 1);

  typedef struct packed {
    lpw_pkg::lpw_mode_t mode;
    logic recovering;
    logic recover_by_reset;
    logic [CW-1:0] count;
    lpw_pkg::lpw_irq_t pend;
    logic chip_reset;
    logic vec_valid;
    logic [15:0] vector;
    lpw_pkg::lpw_gate_t gate;
  } lpw_state_t;

  lpw_state_t st;
  lpw_state_t next_st;

  logic rst_pin_level;
  logic ext_fall;
  logic kbd_fall;
  logic sel_any;
  logic [15:0] sel_vector;
  lpw_pkg::lpw_irq_t sampled;
  logic reset_event;
  logic stop_wake_irq;
  logic wait_wake;

  lpw_sync u_sync_rst (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .pin_i(ext_reset_n_pin_i),
    .level_o(rst_pin_level),
    .fall_o()
  );

  lpw_sync u_sync_irq (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .pin_i(ext_irq_n_pin_i),
    .level_o(),
    .fall_o(ext_fall)
  );

  lpw_sync u_sync_kbd (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .pin_i(keyboard_n_pin_i),
    .level_o(),
    .fall_o(kbd_fall)
  );

  always_comb begin
    sampled = periph_irq_i;
    sampled.ext_irq = ext_fall & ~cfg_i.ext_irq_mask;
    sampled.keyboard_irq = (kbd_fall | periph_irq_i.keyboard_irq)
                           & ~cfg_i.keyboard_irq_mask;
    sampled.timebase = timebase_rollover_i;
  end

  lpw_vector_sel u_vec (
    .irq_i(st.pend),
    .any_o(sel_any),
    .vector_o(sel_vector)
  );

  always_comb begin
    reset_event = ~rst_pin_level | watchdog_timeout_i
                  | (monitor_trip_i & cfg_i.monitor_enable
                     & cfg_i.monitor_reset_enable);
    // Only edge pins, break and timebase may leave stop.
    stop_wake_irq = st.pend.ext_irq | st.pend.keyboard_irq
                    | st.pend.break_irq
                    | (st.pend.timebase & cfg_i.osc_run_in_stop);
    wait_wake = sel_any;
  end

  always_comb begin
    next_st = st;
    next_st.chip_reset = 1'b0;
    next_st.vec_valid = 1'b0;
    // New requests win over the clear when a vector is taken.
    if (vector_taken_i && st.vec_valid) begin
      next_st.pend = '0;
    end
    next_st.pend = next_st.pend | sampled;
    if (st.mode == lpw_pkg::LPW_STOP && !cfg_i.osc_run_in_stop) begin
      next_st.pend.timebase = 1'b0;
    end
    if (st.mode == lpw_pkg::LPW_STOP) begin
      next_st.pend.clkgen_irq = 1'b0;
    end
    if (reset_event) begin
      next_st.pend = '0;
      next_st.chip_reset = 1'b1;
      next_st.vector = `LPW_VEC_RESET;
      next_st.vec_valid = 1'b0;
      if (st.mode == lpw_pkg::LPW_STOP || st.recovering) begin
        next_st.recovering = 1'b1;
        next_st.recover_by_reset = 1'b1;
        next_st.count = cfg_i.short_recovery_select ? SHORT_LOAD
                                                    : LONG_LOAD;
      end
      next_st.mode = lpw_pkg::LPW_RUN;
    end else if (st.recovering) begin
      if (st.count == '0) begin
        next_st.recovering = 1'b0;
        next_st.recover_by_reset = 1'b0;
        next_st.vec_valid = ~st.recover_by_reset;
        next_st.vector = st.recover_by_reset ? `LPW_VEC_RESET : sel_vector;
      end else begin
        next_st.count = st.count - 1'b1;
      end
    end else begin
      case (st.mode)
        lpw_pkg::LPW_RUN: begin
          if (stop_instr_i && cfg_i.stop_enable) begin
            next_st.mode = lpw_pkg::LPW_STOP;
          end else if (wait_instr_i) begin
            next_st.mode = lpw_pkg::LPW_WAIT;
          end else if (sel_any && !st.vec_valid) begin
            next_st.vec_valid = 1'b1;
            next_st.vector = sel_vector;
          end else if (st.vec_valid && !vector_taken_i) begin
            next_st.vec_valid = 1'b1;
          end
        end
        lpw_pkg::LPW_WAIT: begin
          if (wait_wake) begin
            next_st.mode = lpw_pkg::LPW_RUN;
            next_st.vec_valid = 1'b1;
            next_st.vector = sel_vector;
          end
        end
        lpw_pkg::LPW_STOP: begin
          if (stop_wake_irq) begin
            next_st.mode = lpw_pkg::LPW_RUN;
            if (st.pend.ext_irq || st.pend.keyboard_irq) begin
              next_st.recovering = 1'b1;
              next_st.recover_by_reset = 1'b0;
              next_st.count = cfg_i.short_recovery_select ? SHORT_LOAD
                                                          : LONG_LOAD;
            end else begin
              next_st.vec_valid = 1'b1;
              next_st.vector = sel_vector;
            end
          end
        end
        default: begin
          next_st.mode = lpw_pkg::LPW_RUN;
        end
      endcase
    end
    // Gates follow the next mode so they change with the mode output.
    next_st.gate.cpu_clk_en = (next_st.mode == lpw_pkg::LPW_RUN)
                              & ~next_st.recovering;
    next_st.gate.bus_clk_en = ~next_st.recovering
                              & ((next_st.mode != lpw_pkg::LPW_STOP)
                                 | cfg_i.osc_run_in_stop);
    next_st.gate.watchdog_clock_input = next_st.gate.bus_clk_en
        & (next_st.mode != lpw_pkg::LPW_STOP);
    next_st.gate.watchdog_prescaler_clear =
        (next_st.mode == lpw_pkg::LPW_STOP);
    next_st.gate.ser_run = next_st.gate.bus_clk_en
        & (next_st.mode != lpw_pkg::LPW_STOP);
    next_st.gate.spi_run = next_st.gate.bus_clk_en
        & (next_st.mode != lpw_pkg::LPW_STOP);
    next_st.gate.spi_reset = next_st.chip_reset;
    next_st.gate.timer_run = next_st.gate.bus_clk_en
        & (next_st.mode != lpw_pkg::LPW_STOP);
    next_st.gate.timebase_run = ~next_st.recovering
        & ((next_st.mode != lpw_pkg::LPW_STOP)
           | cfg_i.osc_run_in_stop);
    next_st.gate.monitor_run = cfg_i.monitor_enable
        & ((next_st.mode != lpw_pkg::LPW_STOP)
           | cfg_i.monitor_stop_enable);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.mode <= lpw_pkg::LPW_RUN;
      st.recovering <= 1'b0;
      st.recover_by_reset <= 1'b0;
      st.count <= '0;
      st.pend <= '0;
      st.chip_reset <= 1'b1;
      st.vec_valid <= 1'b0;
      st.vector <= `LPW_VEC_RESET;
      st.gate <= 10'h3FB;
    end else begin
      st <= next_st;
    end
  end

  assign mode_o = st.mode;
  assign gate_o = st.gate;
  assign recovering_o = st.recovering;
  assign chip_reset_o = st.chip_reset;
  assign vector_valid_o = st.vec_valid;
  assign vector_o = st.vector;
endmodule : lpw_wake_ctrl
`default_nettype wire

// ### verification/lpw_wake_ctrl_properties.sv
// Port assertions for the wake controller.
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl_properties #(
  parameter int unsigned RECOVERY_LONG = 4096,
  parameter int unsigned RECOVERY_SHORT = 32
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Watched ports
  input wire lpw_pkg::lpw_cfg_t cfg_i,
  input wire logic stop_instr_i,
  input wire logic vector_taken_i,
  input wire lpw_pkg::lpw_mode_t mode_o,
  input wire lpw_pkg::lpw_gate_t gate_o,
  input wire logic recovering_o,
  input wire logic chip_reset_o,
  input wire logic vector_valid_o,
  input wire logic [15:0] vector_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [12:0] rec_cnt;
  logic [12:0] next_rec_cnt;
  wire logic in_run = mode_o == lpw_pkg::LPW_RUN;
  wire logic in_stop = mode_o == lpw_pkg::LPW_STOP;
  // The counter holds the length of the last hold when it ends.
  // A reset keeps reloading the hold, so counting restarts while it lasts.
  always_comb begin
    if (!recovering_o) begin
      next_rec_cnt = 13'h0000;
    end else if (chip_reset_o) begin
      next_rec_cnt = 13'h0001;
    end else begin
      next_rec_cnt = rec_cnt + 13'h0001;
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) rec_cnt <= 13'h0000;
    else rec_cnt <= next_rec_cnt;
  end
  sequence s_stop_req;
    in_run && stop_instr_i && !recovering_o && !chip_reset_o;
  endsequence
  sequence s_stopped;
    in_stop && !gate_o.watchdog_clock_input;
  endsequence
  a_stop_refused:
    assert property ((s_stop_req ##0 !cfg_i.stop_enable) |=> in_run)
    else $error("stop entered while disabled");
  a_stop_entry:
    assert property ((s_stop_req ##0 cfg_i.stop_enable) |=>
      s_stopped ##0 gate_o.watchdog_prescaler_clear)
    else $error("stop entry wrong");
  a_watchdog_off:
    assert property (in_stop |-> !gate_o.watchdog_clock_input)
    else $error("watchdog clock runs in stop");
  a_clocks_low:
    assert property (in_stop && !cfg_i.osc_run_in_stop |->
      !gate_o.cpu_clk_en && !gate_o.bus_clk_en)
    else $error("clocks run in stop");
  a_periph_halt:
    assert property (in_stop |->
      !gate_o.ser_run && !gate_o.spi_run && !gate_o.timer_run)
    else $error("peripheral runs in stop");
  a_timebase_off:
    assert property (in_stop && !cfg_i.osc_run_in_stop |->
      !gate_o.timebase_run)
    else $error("timebase runs without oscillator");
  a_rec_length:
    assert property (!recovering_o && rec_cnt != 13'h0000 |->
      rec_cnt == (cfg_i.short_recovery_select ?
      RECOVERY_SHORT : RECOVERY_LONG))
    else $error("recovery length wrong");
  a_rec_vector:
    assert property ($fell(recovering_o) |->
      vector_valid_o || vector_o == 16'hFFFE)
    else $error("no vector after recovery");
  a_valid_holds:
    assert property (vector_valid_o && !vector_taken_i |=>
      vector_valid_o || chip_reset_o)
    else $error("vector dropped before taken");
  a_rec_clocks_off:
    assert property (recovering_o |->
      !gate_o.cpu_clk_en && !gate_o.bus_clk_en)
    else $error("clocks run during recovery");
  a_monitor_live:
    assert property (in_stop && cfg_i.monitor_enable
      && cfg_i.monitor_stop_enable |-> gate_o.monitor_run)
    else $error("supply monitor halted in stop");
  a_reset_vec:
    assert property (chip_reset_o |-> vector_o == 16'hFFFE && !vector_valid_o)
    else $error("reset vector wrong");
endmodule : lpw_wake_ctrl_properties
`default_nettype wire

// ### verification/lpw_cpu_model.sv
// Behavioural CPU core that accepts the vector offered to it.
`timescale 1ns/1ps
`default_nettype none
module lpw_cpu_model (
  // Clock
  input wire logic ref_clk_i,
  // Controller side
  input wire logic vector_valid_i,
  input wire lpw_pkg::lpw_mode_t mode_i,
  input wire logic [3:0] latency_i,
  // Acceptance
  output logic vector_taken_o
);
  logic [3:0] wait_cnt = 4'h0;
  initial vector_taken_o = 1'b0;
  // A variable fetch delay checks that the vector stands until taken.
  always @(posedge ref_clk_i) begin
    #1;
    if (vector_valid_i === 1'b1 && mode_i === lpw_pkg::LPW_RUN) begin
      if (wait_cnt >= latency_i) begin
        vector_taken_o = 1'b1;
        wait_cnt = 4'h0;
      end else begin
        vector_taken_o = 1'b0;
        wait_cnt = wait_cnt + 4'h1;
      end
    end else begin
      vector_taken_o = 1'b0;
      wait_cnt = 4'h0;
    end
  end
endmodule : lpw_cpu_model
`default_nettype wire

// ### verification/tb_low_power_wake_control.sv
// Self-checking bench for the low power wake controller.
`timescale 1ns/1ps
`default_nettype none
module tb_low_power_wake_control;
  localparam int unsigned RL = 64;
  localparam int unsigned RS = 4;
  typedef struct packed {
    lpw_pkg::lpw_irq_t irq;
    logic [15:0] vec;
  } lpw_row_t;
  lpw_row_t rows [15];
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  lpw_pkg::lpw_cfg_t cfg_i = 8'h00;
  logic wait_instr_i = 1'b0;
  logic stop_instr_i = 1'b0;
  logic vector_taken_i;
  logic ext_reset_n_pin_i = 1'b1;
  logic ext_irq_n_pin_i = 1'b1;
  logic keyboard_n_pin_i = 1'b1;
  logic watchdog_timeout_i = 1'b0;
  logic monitor_trip_i = 1'b0;
  logic timebase_rollover_i = 1'b0;
  lpw_pkg::lpw_irq_t periph_irq_i = 17'h0_0000;
  lpw_pkg::lpw_mode_t mode_o;
  lpw_pkg::lpw_gate_t gate_o;
  logic recovering_o;
  logic chip_reset_o;
  logic vector_valid_o;
  logic [15:0] vector_o;
  logic [3:0] lat = 4'h0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  always #12.5 ref_clk_i = ~ref_clk_i;
  lpw_wake_ctrl #(.RECOVERY_LONG(RL), .RECOVERY_SHORT(RS)) uut (
    .ref_clk_i, .resetn_i, .cfg_i, .wait_instr_i, .stop_instr_i,
    .vector_taken_i, .ext_reset_n_pin_i, .ext_irq_n_pin_i,
    .keyboard_n_pin_i, .watchdog_timeout_i, .monitor_trip_i,
    .timebase_rollover_i, .periph_irq_i, .mode_o, .gate_o, .recovering_o,
    .chip_reset_o, .vector_valid_o, .vector_o);
  lpw_cpu_model cpu (.ref_clk_i, .vector_valid_i(vector_valid_o),
    .mode_i(mode_o), .latency_i(lat), .vector_taken_o(vector_taken_i));
  task tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task fail(input string m);
    $display("mismatch at %0t: %s", $time, m);
    n_mismatch++;
  endtask : fail
  task cmp_val(input logic [15:0] got, input logic [15:0] exp, string m);
    samples_checked++;
    if (got !== exp) fail(m);
  endtask : cmp_val
  task cmp_mode(input lpw_pkg::lpw_mode_t got, lpw_pkg::lpw_mode_t exp);
    samples_checked++;
    if (got !== exp) fail("mode");
  endtask : cmp_mode
  function logic pick(input int s);
    return s == 0 ? vector_valid_o : s == 1 ? recovering_o : chip_reset_o;
  endfunction : pick
  task wait_for(input int s, input logic lvl);
    int i;
    for (i = 0; i < 9000 && pick(s) !== lvl; i++) tick();
    if (i == 9000) begin
      fail("wait timed out");
      give_verdict();
    end
  endtask : wait_for
  task instr(input logic is_stop);
    stop_instr_i = is_stop;
    wait_instr_i = !is_stop;
    tick();
    stop_instr_i = 1'b0;
    wait_instr_i = 1'b0;
    // Let an edge pass so a following call never re-raises in this step.
    tick();
  endtask : instr
  task wake(input logic [15:0] exp);
    wait_for(0, 1'b1);
    cmp_val(vector_o, exp, "vector");
    wait_for(0, 1'b0);
  endtask : wake
  task rec_len(input int exp);
    n = 0;
    wait_for(1, 1'b1);
    while (recovering_o === 1'b1 && n < 9000) begin
      n++;
      tick();
    end
    cmp_val(16'(n), 16'(exp), "recovery length");
  endtask : rec_len
  initial begin
    rows = '{'{17'h0_8000, 16'hFFFC}, '{17'h0_4000, 16'hFFF8},
      '{17'h0_1000, 16'hFFF2}, '{17'h0_0800, 16'hFFF4},
      '{17'h0_0400, 16'hFFF6}, '{17'h0_0200, 16'hFFEC},
      '{17'h0_0100, 16'hFFEE}, '{17'h0_0080, 16'hFFF0},
      '{17'h0_0040, 16'hFFE8}, '{17'h0_0020, 16'hFFEA},
      '{17'h0_0010, 16'hFFE2}, '{17'h0_0008, 16'hFFE4},
      '{17'h0_0004, 16'hFFE6}, '{17'h0_0002, 16'hFFDE},
      '{17'h0_8002, 16'hFFFC}};
    repeat (8) tick();
    cmp_mode(mode_o, lpw_pkg::LPW_RUN);
    cmp_val({6'h00, gate_o}, 16'h03FB, "reset gates");
    cmp_val(vector_o, 16'hFFFE, "reset vector");
    resetn_i = 1'b1;
    wait_for(2, 1'b0);
    foreach (rows[k]) begin
      lat = 4'(k % 3);
      instr(1'b0);
      cmp_mode(mode_o, lpw_pkg::LPW_WAIT);
      periph_irq_i = rows[k].irq;
      repeat (2) tick();
      periph_irq_i = 17'h0_0000;
      wake(rows[k].vec);
    end
    instr(1'b1);
    cmp_mode(mode_o, lpw_pkg::LPW_RUN);
    cfg_i = 8'hD5;
    instr(1'b1);
    cmp_mode(mode_o, lpw_pkg::LPW_STOP);
    cmp_val({6'h00, gate_o}, 16'h0041, "stop gates");
    ext_irq_n_pin_i = 1'b0;
    periph_irq_i = 17'h1_5FFE;
    repeat (8) tick();
    periph_irq_i = 17'h0_0000;
    ext_irq_n_pin_i = 1'b1;
    repeat (4) tick();
    cmp_mode(mode_o, lpw_pkg::LPW_STOP);
    cfg_i = 8'hC0;
    ext_irq_n_pin_i = 1'b0;
    rec_len(RS);
    wake(16'hFFFA);
    ext_irq_n_pin_i = 1'b1;
    cfg_i = 8'h80;
    instr(1'b1);
    keyboard_n_pin_i = 1'b0;
    rec_len(RL);
    wake(16'hFFE0);
    keyboard_n_pin_i = 1'b1;
    cfg_i = 8'hC0;
    instr(1'b1);
    periph_irq_i = 17'h0_8000;
    repeat (2) tick();
    periph_irq_i = 17'h0_0000;
    wake(16'hFFFC);
    cfg_i = 8'hA0;
    instr(1'b1);
    cmp_val({14'h0000, gate_o.bus_clk_en, gate_o.timebase_run},
      16'h0003, "oscillator in stop");
    timebase_rollover_i = 1'b1;
    tick();
    timebase_rollover_i = 1'b0;
    wake(16'hFFDC);
    cfg_i = 8'hC0;
    instr(1'b1);
    ext_reset_n_pin_i = 1'b0;
    wait_for(2, 1'b1);
    tick();
    cmp_val({15'h0000, gate_o.spi_reset}, 16'h0001, "spi reset");
    cmp_val(vector_o, 16'hFFFE, "pin reset vector");
    ext_reset_n_pin_i = 1'b1;
    wait_for(2, 1'b0);
    wait_for(1, 1'b0);
    // The hold length is judged one edge after it ends, with its own setting.
    tick();
    cfg_i = 8'h06;
    instr(1'b0);
    monitor_trip_i = 1'b1;
    wait_for(2, 1'b1);
    monitor_trip_i = 1'b0;
    cmp_mode(mode_o, lpw_pkg::LPW_RUN);
    wait_for(2, 1'b0);
    watchdog_timeout_i = 1'b1;
    wait_for(2, 1'b1);
    watchdog_timeout_i = 1'b0;
    cmp_val(vector_o, 16'hFFFE, "watchdog vector");
    wait_for(2, 1'b0);
    give_verdict();
  end
endmodule : tb_low_power_wake_control
bind lpw_wake_ctrl lpw_wake_ctrl_properties #(
  .RECOVERY_LONG(RECOVERY_LONG), .RECOVERY_SHORT(RECOVERY_SHORT)
) chk (.ref_clk_i, .resetn_i, .cfg_i, .stop_instr_i, .vector_taken_i,
  .mode_o, .gate_o, .recovering_o, .chip_reset_o, .vector_valid_o,
  .vector_o);
`default_nettype wire
